// File: core/can_ctl_defs.svh
`ifndef CAN_CTL_DEFS_SVH
`define CAN_CTL_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_CTL0 5'h00
`define OFS_CTL1 5'h01
`define OFS_BT0 5'h02
`define OFS_BT1 5'h03
`define OFS_IRQ_STATUS 5'h04
`define OFS_IRQ_MASK 5'h05
`define OFS_ACC_CTL 5'h06
`define OFS_ACC_BASE 5'h10
`define ACC_SEL_BIT 3
`define ACC_IDX_W 4

// ----------------------------------------------------------------
// control register 0 fields
// ----------------------------------------------------------------
`define C0_INIT_REQ 0
`define C0_SLEEP_REQ 1
`define C0_WAKE_EN 2

// ----------------------------------------------------------------
// control register 1 fields
// ----------------------------------------------------------------
`define C1_ENABLE 7
`define C1_CLK_SRC 6
`define C1_LOOPBACK 5
`define C1_LISTEN 4
`define C1_UNUSED 3
`define C1_WAKE_FILT 2
`define C1_SLEEP_ACK 1
`define C1_INIT_ACK 0
`define C1_WR_MASK 8'h74

// ----------------------------------------------------------------
// interrupt status fields
// ----------------------------------------------------------------
`define IRQ_TX_DONE 0
`define IRQ_RX_DONE 1
`define IRQ_WAKE 2
`define IRQ_USED_MASK 8'h07

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_CTL1_CFG 8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define WAKE_PULSE_MIN_NS 2000
`define WAKE_PULSE_MIN_CYC ((`WAKE_PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESYNC_RECESSIVE_BITS 11
`define RESYNC_BUS_OFF_SEQS 128

`endif

// File: core/can_ctl_pkg.sv
package can_ctl_pkg;

  typedef enum logic [2:0] {
    st_run = 3'b001,
    st_sleep = 3'b010,
    st_init = 3'b100
  } mode_t;

  typedef struct packed {
    mode_t mode;
    logic init_request;
    logic sleep_request;
    logic wake_enable;
    logic module_enable_bit;
    logic enable_written;
    logic clock_source_select;
    logic loopback_self_test;
    logic bus_monitor_mode;
    logic wake_filter_select;
    logic [7:0] bit_timing_0;
    logic [7:0] bit_timing_1;
    logic [7:0] acceptance_control;
    logic [7:0] irq_status;
    logic [7:0] irq_mask;
    logic [7:0] rdata;
    logic irq;
    logic transmit_pin;
    logic rx_to_engine;
    logic ignore_ack;
    logic freeze_err;
    logic tx_inhibit;
    logic resync_start;
  } ctl_state_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic wake;
  } wake_state_t;

  typedef struct packed {
    logic active;
    logic [3:0] rec_cnt;
    logic [7:0] seq_cnt;
    logic synced;
  } resync_state_t;

endpackage

// File: core/can_wake_filter.sv
`timescale 1ns/1ps
`include "can_ctl_defs.svh"

module can_wake_filter #(
  parameter int MIN_CYC = `WAKE_PULSE_MIN_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic armed,
  input wire logic filter_on,
  input wire logic receive_pin,
  output logic wake
);

  can_ctl_pkg::wake_state_t s_r;
  can_ctl_pkg::wake_state_t s_nxt;

  // ----------------------------------------------------------------
  // dominant level detector with optional low-pass
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.wake = 1'b0;
    if (!armed || receive_pin) begin
      s_nxt.cnt = '0;
    end else if (!filter_on) begin
      s_nxt.wake = 1'b1;
    end else if (s_r.cnt >= 16'(MIN_CYC - 1)) begin
      s_nxt.wake = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign wake = s_r.wake;

endmodule

// File: core/can_resync.sv
`timescale 1ns/1ps
`include "can_ctl_defs.svh"

module can_resync #(
  parameter int REC_BITS = `RESYNC_RECESSIVE_BITS,
  parameter int BUS_OFF_SEQS = `RESYNC_BUS_OFF_SEQS
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic start,
  input wire logic hold,
  input wire logic bus_off,
  input wire logic bit_tick,
  input wire logic rx_bit,
  output logic synced
);

  can_ctl_pkg::resync_state_t s_r;
  can_ctl_pkg::resync_state_t s_nxt;

  // ----------------------------------------------------------------
  // count runs of recessive bits after leaving initialization
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    if (hold) begin
      s_nxt = '0;
    end else if (start) begin
      s_nxt.active = 1'b1;
      s_nxt.rec_cnt = '0;
      s_nxt.seq_cnt = '0;
      s_nxt.synced = 1'b0;
    end else if (s_r.active && bit_tick) begin
      if (!rx_bit) begin
        s_nxt.rec_cnt = '0;
      end else if (s_r.rec_cnt == 4'(REC_BITS - 1)) begin
        s_nxt.rec_cnt = '0;
        s_nxt.seq_cnt = s_r.seq_cnt + 8'h01;
        // bus-off must see the full count of recessive runs
        if (!bus_off || s_r.seq_cnt == 8'(BUS_OFF_SEQS - 1)) begin
          s_nxt.active = 1'b0;
          s_nxt.synced = 1'b1;
        end
      end else begin
        s_nxt.rec_cnt = s_r.rec_cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign synced = s_r.synced;

endmodule

// File: core/can_control_register_one.sv
// Behaviour
// - enable bit write-once, rewritable in special mode
// - enable bit zero inhibits transmit, freezes errors, blocks wake and irq events
// - clock select: oscillator or bus clock
// - loopback feeds transmitter to receiver, pin recessive
// - loopback ignores acknowledge slot bit
// - loopback still raises transmit and receive interrupts
// - listen-only: receive, never drive ack or errors
// - listen-only freezes error counters, no transmission
// - wake filter select: any dominant or long pulse
// - sleep acknowledge set on entering sleep
// - bus activity while asleep wakes, clears acknowledge
// - init acknowledge follows entry and exit of init
// - config registers writable only in initialization mode
// - wake disabled ignores bus traffic while asleep
// - sleep entered only with bus idle
// - resync after 11 recessive bits, 128 runs bus-off
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`include "can_ctl_defs.svh"

module can_control_register_one #(
  parameter int ADDR_W = 5,
  parameter int WAKE_MIN_CYC = `WAKE_PULSE_MIN_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic special_mode,
  input wire logic receive_pin,
  output logic transmit_pin,
  input wire logic engine_tx_bit,
  input wire logic bit_tick,
  input wire logic rx_busy,
  input wire logic tx_pending,
  input wire logic bus_off,
  input wire logic tx_done,
  input wire logic rx_done,
  output logic rx_to_engine,
  output logic ignore_ack,
  output logic freeze_err,
  output logic tx_inhibit,
  output logic ctrl_enable,
  output logic clock_source_select,
  output logic [7:0] bit_timing_0,
  output logic [7:0] bit_timing_1,
  output logic [7:0] acceptance_control,
  output logic bus_synced,
  output logic irq
);

  can_ctl_pkg::ctl_state_t s_r;
  can_ctl_pkg::ctl_state_t s_nxt;

  // acceptance codes in the low half, masks in the high half
  logic [7:0] acc_r [0:15];
  logic wake_hit;
  logic synced_w;
  logic in_init;
  logic asleep;
  logic acc_wr;
  logic [`ACC_IDX_W-1:0] acc_idx;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic [7:0] w1c_set(input logic [7:0] cur, input logic [7:0] clr,
                                         input logic [7:0] set);
    // a new event in the clearing cycle survives
    w1c_set = ((cur & ~clr) | set) & `IRQ_USED_MASK;
  endfunction

  function automatic logic [7:0] ctl1_image(input can_ctl_pkg::ctl_state_t s);
    logic [7:0] v;
    v = `RST_BYTE;
    v[`C1_ENABLE] = s.module_enable_bit;
    v[`C1_CLK_SRC] = s.clock_source_select;
    v[`C1_LOOPBACK] = s.loopback_self_test;
    v[`C1_LISTEN] = s.bus_monitor_mode;
    v[`C1_UNUSED] = 1'b0;
    v[`C1_WAKE_FILT] = s.wake_filter_select;
    v[`C1_SLEEP_ACK] = (s.mode == can_ctl_pkg::st_sleep);
    v[`C1_INIT_ACK] = (s.mode == can_ctl_pkg::st_init);
    ctl1_image = v;
  endfunction

  assign in_init = s_r.init_request && (s_r.mode == can_ctl_pkg::st_init);
  assign asleep = s_r.sleep_request && (s_r.mode == can_ctl_pkg::st_sleep);
  assign acc_idx = addr[`ACC_IDX_W-1:0];
  assign acc_wr = wr && in_init && (addr[ADDR_W-1:`ACC_IDX_W] == `OFS_ACC_BASE >> `ACC_IDX_W);

  // ----------------------------------------------------------------
  // wake detection and bus resynchronisation
  // ----------------------------------------------------------------
  can_wake_filter #(
    .MIN_CYC(WAKE_MIN_CYC)
  ) u_wake (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .armed(asleep && s_r.wake_enable && s_r.module_enable_bit),
    .filter_on(s_r.wake_filter_select),
    .receive_pin(receive_pin),
    .wake(wake_hit)
  );

  can_resync u_resync (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .start(s_r.resync_start),
    .hold(s_r.mode == can_ctl_pkg::st_init),
    .bus_off(bus_off),
    .bit_tick(bit_tick),
    .rx_bit(s_r.rx_to_engine),
    .synced(synced_w)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] ev;
    logic [7:0] clr;
    logic quiet;
    ev = `RST_BYTE;
    clr = `RST_BYTE;
    quiet = 1'b0;
    s_nxt = s_r;
    s_nxt.resync_start = 1'b0;

    // register writes
    if (wr) begin
      if (hit(addr, `OFS_CTL0)) begin
        if (wdata[`C0_INIT_REQ]) begin
          s_nxt.init_request = 1'b1;
        end else if (in_init) begin
          s_nxt.init_request = 1'b0;
        end
        if (wdata[`C0_SLEEP_REQ]) begin
          if (!s_r.irq_status[`IRQ_WAKE]) begin
            s_nxt.sleep_request = 1'b1;
          end
        end else if (asleep) begin
          s_nxt.sleep_request = 1'b0;
        end
        s_nxt.wake_enable = wdata[`C0_WAKE_EN];
      end
      if (hit(addr, `OFS_CTL1) && in_init) begin
        if (special_mode || !s_r.enable_written) begin
          s_nxt.module_enable_bit = wdata[`C1_ENABLE];
          s_nxt.enable_written = !special_mode;
        end
        s_nxt.clock_source_select = wdata[`C1_CLK_SRC];
        s_nxt.loopback_self_test = wdata[`C1_LOOPBACK];
        s_nxt.bus_monitor_mode = wdata[`C1_LISTEN];
        s_nxt.wake_filter_select = wdata[`C1_WAKE_FILT];
      end
      if (hit(addr, `OFS_BT0) && in_init) begin
        s_nxt.bit_timing_0 = wdata;
      end
      if (hit(addr, `OFS_BT1) && in_init) begin
        s_nxt.bit_timing_1 = wdata;
      end
      if (hit(addr, `OFS_ACC_CTL) && in_init) begin
        s_nxt.acceptance_control = wdata;
      end
      if (hit(addr, `OFS_IRQ_STATUS)) begin
        clr = wdata;
      end
      if (hit(addr, `OFS_IRQ_MASK)) begin
        s_nxt.irq_mask = wdata & `IRQ_USED_MASK;
      end
    end

    // mode sequencing
    case (s_r.mode)
      can_ctl_pkg::st_run: begin
        quiet = !rx_busy && !tx_pending;
        if (s_nxt.init_request) begin
          s_nxt.mode = can_ctl_pkg::st_init;
        end else if (s_r.sleep_request && quiet) begin
          s_nxt.mode = can_ctl_pkg::st_sleep;
        end
      end
      can_ctl_pkg::st_sleep: begin
        if (s_nxt.init_request) begin
          s_nxt.mode = can_ctl_pkg::st_init;
        end else if (wake_hit) begin
          s_nxt.mode = can_ctl_pkg::st_run;
          s_nxt.sleep_request = 1'b0;
          ev[`IRQ_WAKE] = 1'b1;
        end else if (!s_nxt.sleep_request) begin
          s_nxt.mode = can_ctl_pkg::st_run;
        end
      end
      can_ctl_pkg::st_init: begin
        if (!s_nxt.init_request) begin
          s_nxt.mode = can_ctl_pkg::st_run;
          s_nxt.resync_start = 1'b1;
        end
      end
      default: begin
        s_nxt.mode = can_ctl_pkg::st_init;
      end
    endcase

    // engine events count in loopback exactly as on the bus
    ev[`IRQ_TX_DONE] = tx_done && s_r.module_enable_bit;
    ev[`IRQ_RX_DONE] = rx_done && s_r.module_enable_bit;
    s_nxt.irq_status = w1c_set(s_r.irq_status, clr, ev);
    s_nxt.irq = |(s_nxt.irq_status & s_nxt.irq_mask);

    // bus side steering
    s_nxt.tx_inhibit = !s_r.module_enable_bit || s_r.bus_monitor_mode ||
                       (s_r.mode != can_ctl_pkg::st_run);
    s_nxt.freeze_err = s_r.bus_monitor_mode || !s_r.module_enable_bit;
    s_nxt.ignore_ack = s_r.loopback_self_test;
    // listen-only keeps the pin recessive, so no ack and no error frame leave
    if (s_nxt.tx_inhibit || s_r.loopback_self_test) begin
      s_nxt.transmit_pin = 1'b1;
    end else begin
      s_nxt.transmit_pin = engine_tx_bit;
    end
    if (s_r.loopback_self_test) begin
      s_nxt.rx_to_engine = engine_tx_bit;
    end else begin
      s_nxt.rx_to_engine = receive_pin;
    end

    // read data, one cycle after the strobe
    s_nxt.rdata = `RST_BYTE;
    if (rd) begin
      if (hit(addr, `OFS_CTL0)) begin
        s_nxt.rdata[`C0_INIT_REQ] = s_r.init_request;
        s_nxt.rdata[`C0_SLEEP_REQ] = s_r.sleep_request;
        s_nxt.rdata[`C0_WAKE_EN] = s_r.wake_enable;
      end else if (hit(addr, `OFS_CTL1)) begin
        s_nxt.rdata = ctl1_image(s_r);
      end else if (hit(addr, `OFS_BT0)) begin
        s_nxt.rdata = s_r.bit_timing_0;
      end else if (hit(addr, `OFS_BT1)) begin
        s_nxt.rdata = s_r.bit_timing_1;
      end else if (hit(addr, `OFS_ACC_CTL)) begin
        s_nxt.rdata = s_r.acceptance_control;
      end else if (hit(addr, `OFS_IRQ_STATUS)) begin
        s_nxt.rdata = s_r.irq_status;
      end else if (hit(addr, `OFS_IRQ_MASK)) begin
        s_nxt.rdata = s_r.irq_mask;
      end else if (addr[ADDR_W-1:`ACC_IDX_W] == `OFS_ACC_BASE >> `ACC_IDX_W) begin
        s_nxt.rdata = acc_r[acc_idx];
      end
    end
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
      s_r.mode <= can_ctl_pkg::st_init;
      s_r.init_request <= 1'b1;
      s_r.transmit_pin <= 1'b1;
      s_r.rx_to_engine <= 1'b1;
      s_r.tx_inhibit <= 1'b1;
      s_r.freeze_err <= 1'b1;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  // acceptance bytes live outside the struct to keep it small
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 16; i++) begin
        acc_r[i] <= `RST_BYTE;
      end
    end else if (ce && acc_wr) begin
      acc_r[acc_idx] <= wdata;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata = s_r.rdata;
  assign transmit_pin = s_r.transmit_pin;
  assign rx_to_engine = s_r.rx_to_engine;
  assign ignore_ack = s_r.ignore_ack;
  assign freeze_err = s_r.freeze_err;
  assign tx_inhibit = s_r.tx_inhibit;
  assign ctrl_enable = s_r.module_enable_bit;
  assign clock_source_select = s_r.clock_source_select;
  assign bit_timing_0 = s_r.bit_timing_0;
  assign bit_timing_1 = s_r.bit_timing_1;
  assign acceptance_control = s_r.acceptance_control;
  assign bus_synced = synced_w;
  assign irq = s_r.irq;

endmodule

// File: tb/can_ctl_monitor.sv
`timescale 1ns/1ps
module can_ctl_monitor (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [4:0] addr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic receive_pin,
  input wire logic transmit_pin,
  input wire logic engine_tx_bit,
  input wire logic rx_to_engine,
  input wire logic ignore_ack,
  input wire logic freeze_err,
  input wire logic tx_inhibit,
  input wire logic ctrl_enable,
  input wire logic clock_source_select
);
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // pin routing
  // ----------------------------------------------------------------
  AST_LOOP_PIN: assert property (ignore_ack && $past(ignore_ack) |-> transmit_pin)
    else $error("loopback pin not recessive");
  AST_LOOP_RX: assert property (ignore_ack && $past(ignore_ack) |-> rx_to_engine == $past(engine_tx_bit))
    else $error("loopback stream not fed back");
  // pins lag by one cycle, so the first edge after reset is skipped
  AST_PIN_RX: assert property (!$past(rst) && !ignore_ack && !$past(ignore_ack) |->
    rx_to_engine == $past(receive_pin))
    else $error("receive pin not passed on");
  AST_LISTEN_PIN: assert property (freeze_err && ctrl_enable && $past(freeze_err && ctrl_enable) |->
    transmit_pin)
    else $error("listen-only drives the bus");
  AST_FREEZE_TX: assert property (freeze_err |-> tx_inhibit)
    else $error("frozen counters but transmit allowed");
  // steering outputs lag the enable bit by one cycle
  AST_DISABLED: assert property (!$past(ctrl_enable) |-> freeze_err && tx_inhibit)
    else $error("disabled controller still active");
  // ----------------------------------------------------------------
  // control register image
  // ----------------------------------------------------------------
  AST_BIT3: assert property ($past(rd) && $past(addr) == 5'h01 |-> rdata[3] == 1'b0)
    else $error("unused bit reads one");
  AST_MIRROR: assert property ($past(rd) && $past(addr) == 5'h01 |->
    rdata[7:6] == {$past(ctrl_enable), $past(clock_source_select)})
    else $error("enable or clock select image wrong");
  AST_ACK_EXCL: assert property ($past(rd) && $past(addr) == 5'h01 |-> rdata[1:0] != 2'b11)
    else $error("sleep and init acknowledged together");
  AST_ACK_INHIBIT: assert property ($past(rd) && $past(addr) == 5'h01 && rdata[1:0] != 2'b00 |->
    tx_inhibit)
    else $error("transmit allowed outside run mode");
endmodule

bind can_control_register_one can_ctl_monitor mon (.ref_clk(ref_clk), .rst(rst), .addr(addr), .rd(rd),
  .rdata(rdata), .receive_pin(receive_pin), .transmit_pin(transmit_pin), .engine_tx_bit(engine_tx_bit),
  .rx_to_engine(rx_to_engine), .ignore_ack(ignore_ack), .freeze_err(freeze_err), .tx_inhibit(tx_inhibit),
  .ctrl_enable(ctrl_enable), .clock_source_select(clock_source_select));

// File: tb/can_bus_node.sv
`timescale 1ns/1ps
module can_bus_node (
  input wire logic ref_clk,
  input wire logic transmit_pin,
  output logic receive_pin
);
  logic remote_level = 1'b1;
  // wired-and bus: idle and released lines sit recessive
  assign receive_pin = transmit_pin & remote_level;
  // remote node holds a dominant level for n cycles
  task automatic dominant(input int n);
    @(posedge ref_clk);
    remote_level <= 1'b0;
    repeat (n) @(posedge ref_clk);
    remote_level <= 1'b1;
  endtask
endmodule

// File: tb/test_can_control_register_one.sv
`timescale 1ns/1ps
`include "can_ctl_defs.svh"
module test_can_control_register_one;
  logic ref_clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_seen = 1'b0, special_mode = 1'b0, ce = 1'b1;
  logic engine_tx_bit = 1'b1, bit_tick = 1'b0, rx_busy = 1'b0, tx_pending = 1'b0, bus_off = 1'b0;
  logic tx_done = 1'b0, rx_done = 1'b0, receive_pin, transmit_pin, rx_to_engine, ignore_ack;
  logic freeze_err, tx_inhibit, ctrl_enable, clock_source_select, bus_synced, irq;
  logic [4:0] addr = 5'h00;
  logic [7:0] wdata = 8'h00, rdata, d, b, bt0, acc_ctl;
  logic [1:0] tick_div = 2'h0;
  logic [7:0] exp_q[$];
  int n_fail = 0, compares = 0;

  can_control_register_one #(.ADDR_W(5), .WAKE_MIN_CYC(4)) dut (.ref_clk(ref_clk), .rst(rst), .ce(ce),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .special_mode(special_mode),
    .receive_pin(receive_pin), .transmit_pin(transmit_pin), .engine_tx_bit(engine_tx_bit),
    .bit_tick(bit_tick), .rx_busy(rx_busy), .tx_pending(tx_pending), .bus_off(bus_off), .tx_done(tx_done),
    .rx_done(rx_done), .rx_to_engine(rx_to_engine), .ignore_ack(ignore_ack), .freeze_err(freeze_err),
    .tx_inhibit(tx_inhibit), .ctrl_enable(ctrl_enable), .clock_source_select(clock_source_select),
    .bit_timing_0(bt0), .bit_timing_1(), .acceptance_control(acc_ctl), .bus_synced(bus_synced), .irq(irq));
  can_bus_node node (.ref_clk(ref_clk), .transmit_pin(transmit_pin), .receive_pin(receive_pin));

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // ----------------------------------------------------------------
  // engine stand-in: random bit stream, sample point every 4 cycles
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    // an idle engine sends recessive, else our own pin could wake us from sleep
    engine_tx_bit <= tx_pending ? 1'($urandom) : 1'b1;
    tick_div <= tick_div + 2'h1;
    bit_tick <= (tick_div == 2'h3);
  end
  // read data stand only in the cycle after the strobe
  always @(posedge ref_clk) begin
    if (rd_seen) chk(rdata, exp_q.pop_front());
    rd_seen <= rd;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [4:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge ref_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // enter init, write the configuration, then leave with ctl0 = c0
  task automatic cfg(input logic [7:0] v, input logic [7:0] c0);
    wr_reg(`OFS_CTL0, 8'h01);
    cyc(2);
    wr_reg(`OFS_CTL1, v);
    wr_reg(`OFS_CTL0, c0);
    cyc(3);
  endtask
  task automatic complete_run();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    complete_run();
  end

  initial begin
    void'($urandom(34946));
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    rd_reg(`OFS_CTL1, 8'h01);
    d = 8'($urandom) | 8'h80;
    wr_reg(`OFS_CTL1, d);
    rd_reg(`OFS_CTL1, (d & 8'hf4) | 8'h01);
    cyc(1);
    chk_pin(clock_source_select, d[6]);
    wr_reg(`OFS_CTL1, d & 8'h7f);
    rd_reg(`OFS_CTL1, (d & 8'hf4) | 8'h01);
    special_mode <= 1'b1;
    wr_reg(`OFS_CTL1, 8'h00);
    cyc(2);
    chk_pin(ctrl_enable, 1'b0);
    chk_pin(tx_inhibit, 1'b1);
    wr_reg(`OFS_CTL1, 8'ha0);
    special_mode <= 1'b0;
    rd_reg(`OFS_CTL1, 8'ha1);
    b = 8'($urandom);
    wr_reg(`OFS_BT0, b);
    wr_reg(`OFS_BT1, ~b);
    rd_reg(`OFS_BT1, ~b);
    ce <= 1'b0;
    wr_reg(`OFS_BT1, b);
    ce <= 1'b1;
    rd_reg(`OFS_BT1, ~b);
    wr_reg(`OFS_ACC_CTL, b ^ 8'h3c);
    wr_reg(`OFS_ACC_BASE, ~b);
    wr_reg(`OFS_CTL0, 8'h00);
    cyc(2);
    rd_reg(`OFS_CTL1, 8'ha0);
    wr_reg(`OFS_BT0, ~b);
    wr_reg(`OFS_CTL1, 8'h80);
    wr_reg(`OFS_ACC_BASE, b);
    rd_reg(`OFS_BT0, b);
    rd_reg(`OFS_CTL1, 8'ha0);
    rd_reg(`OFS_ACC_BASE, ~b);
    chk(bt0, b);
    chk(acc_ctl, b ^ 8'h3c);
    rd_reg(5'h07, 8'h00);
    tx_pending <= 1'b1;
    cyc(2);
    chk_pin(transmit_pin, 1'b1);
    chk_pin(ignore_ack, 1'b1);
    @(posedge ref_clk);
    tx_pending <= 1'b0;
    tx_done <= 1'b1;
    rx_done <= 1'b1;
    @(posedge ref_clk);
    tx_done <= 1'b0;
    rx_done <= 1'b0;
    rd_reg(`OFS_IRQ_STATUS, 8'h03);
    wr_reg(`OFS_IRQ_MASK, 8'h03);
    cyc(2);
    chk_pin(irq, 1'b1);
    wr_reg(`OFS_IRQ_STATUS, 8'h01);
    wr_reg(`OFS_IRQ_MASK, 8'h01);
    cyc(2);
    chk_pin(irq, 1'b0);
    wr_reg(`OFS_IRQ_STATUS, 8'h02);
    rd_reg(`OFS_IRQ_STATUS, 8'h00);
    cfg(8'h90, 8'h00);
    chk_pin(tx_inhibit, 1'b1);
    chk_pin(freeze_err, 1'b1);
    chk_pin(transmit_pin, 1'b1);
    cfg(8'h80, 8'h00);
    chk_pin(tx_inhibit, 1'b0);
    chk_pin(freeze_err, 1'b0);
    @(posedge ref_clk) rx_busy <= 1'b1;
    tx_pending <= 1'b1;
    wr_reg(`OFS_CTL0, 8'h06);
    cyc(4);
    rd_reg(`OFS_CTL1, 8'h80);
    tx_pending <= 1'b0;
    cyc(4);
    rd_reg(`OFS_CTL1, 8'h80);
    @(posedge ref_clk) rx_busy <= 1'b0;
    cyc(4);
    rd_reg(`OFS_CTL1, 8'h82);
    node.dominant(1);
    cyc(6);
    rd_reg(`OFS_CTL1, 8'h80);
    rd_reg(`OFS_CTL0, 8'h04);
    rd_reg(`OFS_IRQ_STATUS, 8'h04);
    wr_reg(`OFS_IRQ_STATUS, 8'h04);
    wr_reg(`OFS_CTL0, 8'h02);
    cyc(4);
    node.dominant(2);
    cyc(6);
    rd_reg(`OFS_CTL1, 8'h82);
    wr_reg(`OFS_CTL0, 8'h00);
    cyc(3);
    rd_reg(`OFS_CTL1, 8'h80);
    cfg(8'h84, 8'h06);
    rd_reg(`OFS_CTL1, 8'h86);
    node.dominant(2);
    cyc(8);
    rd_reg(`OFS_CTL1, 8'h86);
    node.dominant(8);
    cyc(6);
    rd_reg(`OFS_CTL1, 8'h84);
    wr_reg(`OFS_IRQ_STATUS, 8'h04);
    // nine sample points is short of eleven recessive bits
    cfg(8'h80, 8'h00);
    cyc(33);
    chk_pin(bus_synced, 1'b0);
    cyc(23);
    chk_pin(bus_synced, 1'b1);
    @(posedge ref_clk) bus_off <= 1'b1;
    cfg(8'h80, 8'h00);
    cyc(5560);
    chk_pin(bus_synced, 1'b0);
    cyc(140);
    chk_pin(bus_synced, 1'b1);
    cyc(4);
    complete_run();
  end
endmodule
